// ===== dv/charger_status_asserts.sv
// assertions on the charger status pin logic ports
`timescale 1ns/100ps
module charger_status_asserts (
	input wire       CLK,
	input wire       RESET_N,
	input wire [2:0] CHARGE_PHASE,
	input wire       INPUT_VALID,
	input wire       BUCK_SWITCHING,
	input wire       REVERSE_BOOST_EN,
	input wire       MCU_AUX_LOW,
	input wire       DETECT_DONE,
	input wire       CFG_WRITE,
	input wire [5:0] CFG_READBACK,
	input wire       CHARGE_STATUS_N_OE,
	input wire       INPUT_GOOD_N_OE,
	input wire       AUX_STATUS_N_OE,
	input wire       SS_ENABLE,
	input wire       SS_PATTERN_TRI,
	input wire       SHIP_MODE,
	input wire       CHARGE_STOP,
	input wire       BATT_SYS_SWITCH
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	// readback lags the live setting, so skip cycles near a write
	a_good_in: assert property (INPUT_VALID && BUCK_SWITCHING |=> INPUT_GOOD_N_OE)
		else $error("input good not low");
	a_good_boost: assert property (REVERSE_BOOST_EN |=> INPUT_GOOD_N_OE)
		else $error("input good not low in boost");
	a_chg_solid: assert property (CHARGE_PHASE inside {3'h4, 3'h5} |=> CHARGE_STATUS_N_OE)
		else $error("charge status not solid");
	a_chg_off: assert property (CHARGE_PHASE inside {3'h0, 3'h6} |=> !CHARGE_STATUS_N_OE)
		else $error("charge status not released");
	a_cfg_cause: assert property ($changed(CFG_READBACK) |-> $past(CFG_WRITE, 2))
		else $error("config changed without write");
	a_ss_follow: assert property (SS_ENABLE == CFG_READBACK[0] &&
		SS_PATTERN_TRI == CFG_READBACK[1])
		else $error("spread spectrum mismatch");
	a_stop_switch: assert property (CHARGE_STOP |-> !BATT_SYS_SWITCH)
		else $error("switch on while charge stopped");
	a_aux_mcu: assert property (!$past(CFG_WRITE) && !CFG_WRITE && CFG_READBACK[3] && MCU_AUX_LOW
		|=> AUX_STATUS_N_OE)
		else $error("aux not under controller");
	a_aux_detect: assert property (!$past(CFG_WRITE) && !CFG_WRITE && CFG_READBACK[3:2] == 2'h1
		&& !DETECT_DONE |=> AUX_STATUS_N_OE)
		else $error("aux not low before detection");
	a_ship_set: assert property ($rose(CFG_READBACK[4]) |-> ##[0:1] SHIP_MODE)
		else $error("ship mode not entered");
endmodule

// ===== dv/charger_status_pin_logic_test.sv
// self-checking bench for the charger status pin logic
`timescale 1ns/100ps
module charger_status_pin_logic_test;
	logic       CLK = '0, RESET_N = '0, INPUT_VALID = '0, BUCK_SWITCHING = '0;
	logic       REVERSE_BOOST_EN = '0, TIMER_FAULT = '0, THERMAL_SHUTDOWN = '0, SYS_RAIL_FAULT = '0;
	logic       DETECT_DONE = '0, DETECT_DCP = '0, MCU_AUX_LOW = '0, EXT_SHIP_CTRL = '0;
	logic       PROT_WRITE = '0, CFG_WRITE = '0;
	logic [2:0] CHARGE_PHASE = '0;
	logic [1:0] PROT_DATA = '0;
	logic [5:0] CFG_DATA = '0;
	wire        CHARGE_STATUS_N_OUT, CHARGE_STATUS_N_OE, INPUT_GOOD_N_OUT, INPUT_GOOD_N_OE;
	wire        AUX_STATUS_N_OUT, AUX_STATUS_N_OE, SHIP_MODE, SYSTEM_RESET, BATT_SYS_SWITCH;
	wire        CHARGE_STOP, SS_ENABLE, SS_PATTERN_TRI, UNLOCKED, charge_pin, good_pin, aux_pin;
	wire  [5:0] CFG_READBACK;
	int         fails = 0, check_count = 0;
	charger_status_pin_logic i_charger_status_pin_logic (.*);
	status_pin_loads i_status_pin_loads (.charge_oe(CHARGE_STATUS_N_OE), .good_oe(INPUT_GOOD_N_OE),
		.aux_oe(AUX_STATUS_N_OE), .charge_pin(charge_pin), .good_pin(good_pin), .aux_pin(aux_pin));
	initial forever #2 CLK = ~CLK;
	task automatic step(input int n);
		repeat (n) @(negedge CLK);
	endtask
	task automatic ckv(input logic [5:0] g, input logic [5:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic ck(input logic g, input logic e);
		ckv({5'h0, g}, {5'h0, e});
	endtask
	// one-cycle strobe on either the key field or the settings
	task automatic wr(input logic prot, input logic [5:0] d);
		PROT_WRITE = prot;
		CFG_WRITE = !prot;
		PROT_DATA = d[1:0];
		CFG_DATA = d;
		step(1);
		PROT_WRITE = 1'b0;
		CFG_WRITE = 1'b0;
		step(1);
	endtask
	task automatic complete_run;
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#400000;
		fails++;
		complete_run;
	end
	initial begin
		step(5);
		RESET_N = 1'b1;
		step(1);
		ck(BATT_SYS_SWITCH, 1'b1);
		ck(SYSTEM_RESET, 1'b0);
		ck(CHARGE_STATUS_N_OUT | INPUT_GOOD_N_OUT | AUX_STATUS_N_OUT, 1'b0);
		wr(0, 6'h01);
		wr(1, 6'h02);
		wr(0, 6'h01);
		step(3);
		ckv(CFG_READBACK, 6'h00);
		ck(UNLOCKED, 1'b0);
		wr(1, 6'h03);
		ck(UNLOCKED, 1'b1);
		for (int i = 0; i < 4; i++) begin
			wr(0, 6'(i));
			step(3);
			ckv(CFG_READBACK, 6'(i));
			ck(SS_ENABLE, i[0]);
			ck(SS_PATTERN_TRI, i[1]);
		end
		for (int i = 0; i < 8; i++) begin
			{INPUT_VALID, BUCK_SWITCHING, REVERSE_BOOST_EN} = 3'(i);
			step(2);
			ck(good_pin, !(i[2] && i[1] || i[0]));
		end
		for (int p = 0; p < 7; p++) begin
			CHARGE_PHASE = 3'(p);
			step(2);
			ck(charge_pin, !(p == 4 || p == 5));
		end
		for (int i = 0; i < 3; i++) begin
			wr(0, 6'h04);
			wr(0, 6'h00);
			step(3);
			ck(aux_pin, 1'b1);
			{TIMER_FAULT, THERMAL_SHUTDOWN, SYS_RAIL_FAULT} = 3'h4 >> i;
			step(1);
			{TIMER_FAULT, THERMAL_SHUTDOWN, SYS_RAIL_FAULT} = 3'h0;
			step(2);
			ck(aux_pin, 1'b0);
		end
		wr(0, 6'h04);
		step(3);
		ck(aux_pin, 1'b0);
		DETECT_DONE = 1'b1;
		for (int i = 0; i < 2; i++) begin
			DETECT_DCP = i[0];
			step(2);
			ck(aux_pin, !i[0]);
		end
		wr(0, 6'h08);
		for (int i = 0; i < 2; i++) begin
			MCU_AUX_LOW = i[0];
			step(3);
			ck(aux_pin, !i[0]);
		end
		wr(0, 6'h10);
		step(3);
		ck(SHIP_MODE, 1'b1);
		wr(0, 6'h00);
		step(3);
		ck(SHIP_MODE, 1'b0);
		CHARGE_PHASE = 3'h3;
		EXT_SHIP_CTRL = 1'b1;
		step(5);
		ck(CHARGE_STOP, 1'b1);
		ck(BATT_SYS_SWITCH, 1'b0);
		EXT_SHIP_CTRL = 1'b0;
		step(5);
		ck(CHARGE_STOP, 1'b0);
		ck(BATT_SYS_SWITCH, 1'b1);
		wr(0, 6'h20);
		EXT_SHIP_CTRL = 1'b1;
		step(5);
		ck(CHARGE_STOP, 1'b0);
		ck(BATT_SYS_SWITCH, 1'b1);
		EXT_SHIP_CTRL = 1'b0;
		wr(0, 6'h10);
		EXT_SHIP_CTRL = 1'b1;
		step(1000);
		ck(SHIP_MODE, 1'b1);
		ck(BATT_SYS_SWITCH, 1'b0);
		ck(SYSTEM_RESET, 1'b0);
		EXT_SHIP_CTRL = 1'b0;
		complete_run;
	end
endmodule
bind charger_status_pin_logic charger_status_asserts i_charger_status_asserts (.*);

// ===== dv/status_pin_loads.sv
// pull-up loads on the three open-drain status pins
`timescale 1ns/100ps
module status_pin_loads (
	input  wire charge_oe,
	input  wire good_oe,
	input  wire aux_oe,
	output wire charge_pin,
	output wire good_pin,
	output wire aux_pin
);
	// nobody else drives these pins, so a released pin sits at the pull-up
	assign charge_pin = ~charge_oe;
	assign good_pin   = ~good_oe;
	assign aux_pin    = ~aux_oe;
endmodule

// ===== rtl/charger_status_defines.vh
// constants for the charger status and control pin logic
`ifndef CHARGER_STATUS_DEFINES_VH
`define CHARGER_STATUS_DEFINES_VH

`define CLK_MHZ            250
`define BLINK_HZ           1
`define BLINK_HALF_CYCLES  ((`CLK_MHZ * 1000000) / (2 * `BLINK_HZ))
`define SHIP_EXIT_MS       10
`define SHIP_EXIT_CYCLES   (`SHIP_EXIT_MS * `CLK_MHZ * 1000)
`define SYS_RESET_S        10
`define SYS_RESET_CYCLES   (`SYS_RESET_S * `CLK_MHZ * 32'd1000000)
`define UNLOCK_KEY         2'h3
`define PROT_RESET         2'h0

`define PH_NONE            3'h0
`define PH_TRICKLE         3'h1
`define PH_PRECHG          3'h2
`define PH_FAST            3'h3
`define PH_TOPOFF          3'h4
`define PH_DONE            3'h5
`define PH_FAULT           3'h6

`define CFG_SS_EN          0
`define CFG_SS_PAT         1
`define CFG_AUX_USAGE      2
`define CFG_AUX_EXT        3
`define CFG_FSHIP          4
`define CFG_QRST           5
`define CFG_W              6
`define CFG_RESET          6'h00

`endif

// ===== rtl/charger_status_pin_logic.v
// status pins, ship-control input and locked configuration of a battery charger
//
// Behaviour
// - charge status blinks 1Hz 50% during trickle, precharge and fast charge
// - charge status open-drain low in top-off/done, released on no input or fault
// - input good low when input valid and buck is switching
// - input good also low while reverse boost is enabled
// - fault usage: aux released, driven low on timer, thermal or rail fault
// - detection usage: aux low, after detection low for DCP, released otherwise
// - a setting selects aux usage: fault or detection done
// - a setting selects aux source: state machine or external controller
// - ship-control input active high, action depends on ship, switch, input state
// - in factory ship mode a 10ms hold exits ship mode
// - out of ship mode, reset sel 0, no input: 10s hold enters system reset
// - releasing the input after system reset turns battery switch back on
// - charging with valid input, out of ship mode, reset sel 0: high input stops charging, switch off
// - factory ship bit enters ship mode when set, leaves it when cleared
// - spread-spectrum enable bit turns modulation on or off
// - configuration writes take effect only after unlock key 0x3
// - pattern bit selects pseudo-random or triangular modulation
`timescale 1ns/100ps
`include "charger_status_defines.vh"

module charger_status_pin_logic (
	input  wire        CLK,
	input  wire        RESET_N,
	input  wire [2:0]  CHARGE_PHASE,
	input  wire        INPUT_VALID,
	input  wire        BUCK_SWITCHING,
	input  wire        REVERSE_BOOST_EN,
	input  wire        TIMER_FAULT,
	input  wire        THERMAL_SHUTDOWN,
	input  wire        SYS_RAIL_FAULT,
	input  wire        DETECT_DONE,
	input  wire        DETECT_DCP,
	input  wire        MCU_AUX_LOW,
	input  wire        EXT_SHIP_CTRL,
	input  wire        PROT_WRITE,
	input  wire [1:0]  PROT_DATA,
	input  wire        CFG_WRITE,
	input  wire [5:0]  CFG_DATA,
	output reg         CHARGE_STATUS_N_OUT,
	output reg         CHARGE_STATUS_N_OE,
	output reg         INPUT_GOOD_N_OUT,
	output reg         INPUT_GOOD_N_OE,
	output reg         AUX_STATUS_N_OUT,
	output reg         AUX_STATUS_N_OE,
	output reg         SHIP_MODE,
	output reg         SYSTEM_RESET,
	output reg         BATT_SYS_SWITCH,
	output reg         CHARGE_STOP,
	output reg         SS_ENABLE,
	output reg         SS_PATTERN_TRI,
	output reg         UNLOCKED,
	output reg  [5:0]  CFG_READBACK
);

	reg        ship_meta;
	reg        ship_sync;
	reg [1:0]  prot;
	reg [5:0]  cfg;
	reg [27:0] blink_cnt;
	reg        blink;
	reg [31:0] hold_cnt;
	reg        fship_last;
	reg        rst_mode;
	reg        aux_fault;

	reg [1:0]  next_prot;
	reg [5:0]  next_cfg;
	reg [27:0] next_blink_cnt;
	reg        next_blink;
	reg [31:0] next_hold_cnt;
	reg        next_ship_mode;
	reg        next_rst_mode;
	reg        next_system_reset;
	reg        next_batt_switch;
	reg        next_charge_stop;
	reg        next_aux_fault;
	reg        next_charge_oe;
	reg        next_good_oe;
	reg        next_aux_oe;
	reg        next_ss_enable;
	reg        next_ss_pattern;
	reg        next_unlocked;
	reg [5:0]  next_readback;

	wire       unlocked;
	wire       charging;
	wire       solid;
	wire       fault_evt;
	wire       exit_hit;
	wire       reset_hit;
	wire       press_stop;

	assign unlocked  = (prot == `UNLOCK_KEY);
	assign charging  = (CHARGE_PHASE == `PH_TRICKLE) ||
		(CHARGE_PHASE == `PH_PRECHG) ||
		(CHARGE_PHASE == `PH_FAST);
	assign solid     = (CHARGE_PHASE == `PH_TOPOFF) || (CHARGE_PHASE == `PH_DONE);
	assign fault_evt = TIMER_FAULT || THERMAL_SHUTDOWN || SYS_RAIL_FAULT;
	assign exit_hit  = (hold_cnt == `SHIP_EXIT_CYCLES - 1);
	assign reset_hit = (hold_cnt == `SYS_RESET_CYCLES - 1);
	// a press while charging from a valid input pauses charge and opens the switch
	assign press_stop = !SHIP_MODE && !cfg[`CFG_QRST] && INPUT_VALID && charging && ship_sync;

	// the ship pin comes from a pushbutton, so it is synchronised first
	always @(posedge CLK) begin
		if (!RESET_N) begin
			ship_meta <= 1'b0;
			ship_sync <= 1'b0;
		end else begin
			ship_meta <= EXT_SHIP_CTRL;
			ship_sync <= ship_meta;
		end
	end

	// key must be loaded first; configuration writes are dropped while locked
	always @* begin
		next_prot = prot;
		next_cfg  = cfg;
		if (PROT_WRITE) begin
			next_prot = PROT_DATA;
		end
		if (CFG_WRITE && unlocked) begin
			next_cfg = CFG_DATA;
		end
	end

	always @(posedge CLK) begin
		if (!RESET_N) begin
			prot <= `PROT_RESET;
			cfg  <= `CFG_RESET;
		end else begin
			prot <= next_prot;
			cfg  <= next_cfg;
		end
	end

	// half-period divider from the system clock gives the 1Hz blink;
	// it restarts on each charge entry, so the first half is always released
	always @* begin
		next_blink_cnt = blink_cnt + 28'h0000001;
		next_blink     = blink;
		if (!charging) begin
			next_blink_cnt = 28'h0000000;
			next_blink     = 1'b1;
		end else if (blink_cnt == `BLINK_HALF_CYCLES - 1) begin
			next_blink_cnt = 28'h0000000;
			next_blink     = ~blink;
		end
	end

	always @(posedge CLK) begin
		if (!RESET_N) begin
			blink_cnt <= 28'h0000000;
			blink     <= 1'b1;
		end else begin
			blink_cnt <= next_blink_cnt;
			blink     <= next_blink;
		end
	end

	// hold time counter saturates, so each threshold fires once per press
	always @* begin
		next_hold_cnt = hold_cnt;
		if (!ship_sync) begin
			next_hold_cnt = 32'h00000000;
		end else if (hold_cnt != 32'hffffffff) begin
			next_hold_cnt = hold_cnt + 32'h00000001;
		end
	end

	always @(posedge CLK) begin
		if (!RESET_N) begin
			hold_cnt <= 32'h00000000;
		end else begin
			hold_cnt <= next_hold_cnt;
		end
	end

	// ship mode follows the configuration bit on each change; a press may leave it,
	// and it stays left until the bit changes value again
	always @* begin
		next_ship_mode    = SHIP_MODE;
		next_rst_mode     = rst_mode;
		next_system_reset = rst_mode;
		next_charge_stop  = press_stop;
		next_batt_switch  = 1'b1;
		if (cfg[`CFG_FSHIP] != fship_last) begin
			next_ship_mode = cfg[`CFG_FSHIP];
		end else if (SHIP_MODE && ship_sync && exit_hit) begin
			next_ship_mode = 1'b0;
		end
		// reset mode waits for release so the rail does not return mid-press
		if (!SHIP_MODE && !cfg[`CFG_QRST] && !INPUT_VALID && ship_sync && reset_hit) begin
			next_rst_mode = 1'b1;
		end else if (rst_mode && !ship_sync) begin
			next_rst_mode = 1'b0;
		end
		if (SHIP_MODE || rst_mode || press_stop) begin
			next_batt_switch = 1'b0;
		end
	end

	always @(posedge CLK) begin
		if (!RESET_N) begin
			SHIP_MODE       <= 1'b0;
			fship_last      <= 1'b0;
			rst_mode        <= 1'b0;
			SYSTEM_RESET    <= 1'b0;
			BATT_SYS_SWITCH <= 1'b1;
			CHARGE_STOP     <= 1'b0;
		end else begin
			SHIP_MODE       <= next_ship_mode;
			fship_last      <= cfg[`CFG_FSHIP];
			rst_mode        <= next_rst_mode;
			SYSTEM_RESET    <= next_system_reset;
			BATT_SYS_SWITCH <= next_batt_switch;
			CHARGE_STOP     <= next_charge_stop;
		end
	end

	// fault indication latches; a fault in the same cycle as a clear wins,
	// but while detection is shown the latch clears again in the first cycle without a fault
	always @* begin
		next_aux_fault = aux_fault;
		if (fault_evt) begin
			next_aux_fault = 1'b1;
		end else if (cfg[`CFG_AUX_USAGE]) begin
			next_aux_fault = 1'b0;
		end
	end

	always @(posedge CLK) begin
		if (!RESET_N) begin
			aux_fault <= 1'b0;
		end else begin
			aux_fault <= next_aux_fault;
		end
	end

	// pin enables are decided here and registered below
	always @* begin
		if (charging) begin
			next_charge_oe = ~blink;
		end else begin
			next_charge_oe = solid;
		end
		next_good_oe = (INPUT_VALID && BUCK_SWITCHING) ||
			REVERSE_BOOST_EN;
		if (cfg[`CFG_AUX_EXT]) begin
			next_aux_oe = MCU_AUX_LOW;
		end else if (cfg[`CFG_AUX_USAGE]) begin
			next_aux_oe = !DETECT_DONE || DETECT_DCP;
		end else begin
			next_aux_oe = aux_fault || fault_evt;
		end
	end

	// settings are mirrored a cycle later so every output leaves a flip-flop
	always @* begin
		next_ss_enable  = cfg[`CFG_SS_EN];
		next_ss_pattern = cfg[`CFG_SS_PAT];
		next_unlocked   = unlocked;
		next_readback   = cfg;
	end

	always @(posedge CLK) begin
		if (!RESET_N) begin
			CHARGE_STATUS_N_OE <= 1'b0;
			INPUT_GOOD_N_OE    <= 1'b0;
			AUX_STATUS_N_OE    <= 1'b0;
			SS_ENABLE          <= 1'b0;
			SS_PATTERN_TRI     <= 1'b0;
			UNLOCKED           <= 1'b0;
			CFG_READBACK       <= `CFG_RESET;
		end else begin
			CHARGE_STATUS_N_OE <= next_charge_oe;
			INPUT_GOOD_N_OE    <= next_good_oe;
			AUX_STATUS_N_OE    <= next_aux_oe;
			SS_ENABLE          <= next_ss_enable;
			SS_PATTERN_TRI     <= next_ss_pattern;
			UNLOCKED           <= next_unlocked;
			CFG_READBACK       <= next_readback;
		end
	end

	// open-drain pins only ever drive low; the enables carry the state
	always @(posedge CLK) begin
		if (!RESET_N) begin
			CHARGE_STATUS_N_OUT <= 1'b0;
			INPUT_GOOD_N_OUT    <= 1'b0;
			AUX_STATUS_N_OUT    <= 1'b0;
		end else begin
			CHARGE_STATUS_N_OUT <= 1'b0;
			INPUT_GOOD_N_OUT    <= 1'b0;
			AUX_STATUS_N_OUT    <= 1'b0;
		end
	end

endmodule
